// ### design/igfsh_glitch_filter.sv
`timescale 1ns/1ns
module igfsh_glitch_filter
#(
	parameter int FACTOR_W = 5
)
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic line_in,
	input wire logic [FACTOR_W-1:0] factor_in,
	output logic line_out
);
	import igfsh_pkg::*;

	logic line_q;
	logic [FACTOR_W-1:0] cnt_q;
	logic [FACTOR_W-1:0] cnt_d;
	logic differ;
	logic accept;

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (FACTOR_W < 1 || FACTOR_W > 8)
	begin : g_bad_width
		$error("glitch filter width out of range");
	end

	// New level is taken only after factor+1 steady differing samples
	assign differ = line_in != line_q;
	assign accept = differ && (cnt_q >= factor_in);
	assign cnt_d = (differ && !accept) ? cnt_q + 1'b1 : '0;

	// Filtered level and run counter
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
		begin
			line_q <= 1'b1;
			cnt_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_d;
			if (accept)
				line_q <= line_in;
		end
	end

	assign line_out = line_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_filter_pass_run: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(line_out != $past(line_out)) |-> ($past(cnt_q) >= $past(factor_in)))
		else $error("filter passed a pulse shorter than the factor");
	chk_filter_bypass: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(factor_in == '0 && line_in != line_out) |=> (line_out == $past(line_in)))
		else $error("zero factor did not bypass the filter");

endmodule

// ### design/igfsh_pkg.sv
package igfsh_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam int FACTOR_W = 5;
	localparam int BITCNT_W = 4;
	localparam int EVT_W = 3;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADR_W-1:0] OFS_FILTER_CTL = 8'h00;
	localparam logic [ADR_W-1:0] OFS_MODULE_CTL = 8'h04;
	localparam logic [ADR_W-1:0] OFS_MODULE_STS = 8'h08;
	localparam logic [ADR_W-1:0] OFS_EVT_STS = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_EVT_MASK = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_STOP_HOLD_EN = 7;
	localparam int POS_STOP_FLAG = 6;
	localparam int POS_STOP_IRQ_EN = 5;
	localparam int POS_FACTOR_LSB = 0;
	localparam int POS_MODULE_EN = 0;
	localparam int POS_MODULE_IRQ_EN = 1;
	localparam int POS_TCF = 0;
	localparam int POS_MODULE_IRQ_FLAG = 1;
	localparam int POS_XFER_ACTIVE = 2;
	localparam int POS_STOP_ACK = 3;
	localparam int POS_EVT_TCF = 0;
	localparam int POS_EVT_STOP = 1;
	localparam int POS_EVT_SACK = 2;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic RST_STOP_HOLD_EN = 1'b0;
	localparam logic RST_STOP_IRQ_EN = 1'b0;
	localparam logic [FACTOR_W-1:0] RST_FACTOR = 5'h00;
	localparam logic RST_MODULE_EN = 1'b0;
	localparam logic RST_MODULE_IRQ_EN = 1'b0;
	localparam logic [EVT_W-1:0] RST_EVT_MASK = 3'h0;
	localparam logic [BITCNT_W-1:0] BITS_PER_BYTE = 4'h9;
	localparam int NUM_LINES = 2;
	localparam int LINE_SCL = 0;
	localparam int LINE_SDA = 1;

endpackage

// ### design/igfsh_top.sv
// Functional notes
// - With stop hold enabled, an enabled module's stop-mode acknowledge waits while a byte is in flight.
// - Held request is acknowledged once the byte and its acknowledge bit finish.
// - With hold enabled, idle or disabled module acknowledges stop mode at once.
// - Transfer-complete interrupt is raised after wake when module irq was enabled.
// - Bus stop flag sets whenever a STOP condition is seen on the bus.
// - Bus stop flag clears only by writing one; writing zero keeps it.
// - Stop interrupt enable gates whether a seen STOP requests a module interrupt.
// - Stop flag must be cleared first, else module irq flag sets again.
// - Filter factor sets largest rejected glitch in cycles; zero means bypass.
// - STOP is a rising data line while the clock line is high.
`timescale 1ns/1ns
module igfsh_top
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [igfsh_pkg::ADR_W-1:0] wb_adr_in,
	input wire logic [igfsh_pkg::SEL_W-1:0] wb_sel_in,
	input wire logic [igfsh_pkg::DAT_W-1:0] wb_dat_in,
	output logic [igfsh_pkg::DAT_W-1:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic stop_req_in,
	output logic stop_ack_out,
	output logic irq_out
);
	import igfsh_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [NUM_LINES-1:0] sync1_q;
	logic [NUM_LINES-1:0] sync2_q;
	logic [NUM_LINES-1:0] filt;
	logic [NUM_LINES-1:0] prev_q;
	logic stop_hold_enable_q;
	logic bus_stop_detected_flag_q;
	logic bus_stop_detected_flag_d;
	logic bus_stop_irq_enable_q;
	logic [FACTOR_W-1:0] glitch_filter_factor_q;
	logic module_enable_q;
	logic module_irq_enable_q;
	logic module_irq_flag_q;
	logic module_irq_flag_d;
	logic transfer_complete_flag_q;
	logic transfer_complete_flag_d;
	logic xfer_active_q;
	logic xfer_active_d;
	logic [BITCNT_W-1:0] bit_cnt_q;
	logic [BITCNT_W-1:0] bit_cnt_d;
	logic [EVT_W-1:0] evt_q;
	logic [EVT_W-1:0] evt_d;
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_mask_q;
	logic stop_ack_q;
	logic stop_ack_d;
	logic irq_q;
	logic irq_d;
	logic ack_q;
	logic [DAT_W-1:0] dat_q;
	logic [DAT_W-1:0] rd_mux;
	logic req;
	logic wr_take;
	logic rd_take;
	logic wr_filter;
	logic wr_module_ctl;
	logic wr_module_sts;
	logic wr_evt_sts;
	logic wr_evt_mask;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic byte_done;
	logic byte_in_flight;
	logic hold_ok;
	logic tcf_set;

	// Address match used by every register strobe
	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
		hit = adr == ofs;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------

	// Two stages per pin; only the second stage feeds the filters
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
		begin
			sync1_q <= '1;
			sync2_q <= '1;
		end
		else
		begin
			sync1_q <= {sda_in, scl_in};
			sync2_q <= sync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Glitch filters, one per line
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_LINES; i++)
	begin : g_filter
		igfsh_glitch_filter
		#(
			.FACTOR_W(FACTOR_W)
		)
		u_filter
		(
			.ref_clk_in(ref_clk_in),
			.rstn_in(rstn_in),
			.line_in(sync2_q[i]),
			.factor_in(glitch_filter_factor_q),
			.line_out(filt[i])
		);
	end

	// Previous filtered levels for edge finding
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
			prev_q <= '1;
		else
			prev_q <= filt;
	end

	// ----------------------------------------------------------------
	// Bus condition detection
	// ----------------------------------------------------------------

	// Edges and conditions taken from filtered lines only
	assign scl_rise = filt[LINE_SCL] && !prev_q[LINE_SCL];
	assign scl_fall = !filt[LINE_SCL] && prev_q[LINE_SCL];
	assign start_det = prev_q[LINE_SCL] && filt[LINE_SCL] && prev_q[LINE_SDA] && !filt[LINE_SDA];
	assign stop_det = prev_q[LINE_SCL] && filt[LINE_SCL] && !prev_q[LINE_SDA] && filt[LINE_SDA];

	// Bit counter: a byte ends on the clock fall after the ninth bit
	assign byte_done = xfer_active_q && scl_fall && (bit_cnt_q == BITS_PER_BYTE);
	assign byte_in_flight = xfer_active_q && (bit_cnt_q != '0);
	assign bit_cnt_d = (start_det || stop_det || byte_done) ? '0 :
		(xfer_active_q && scl_rise) ? bit_cnt_q + 1'b1 : bit_cnt_q;
	assign xfer_active_d = start_det ? 1'b1 : (stop_det ? 1'b0 : xfer_active_q);

	// Transfer complete: set at byte end, cleared by the next byte's first bit
	assign tcf_set = byte_done;
	assign transfer_complete_flag_d = tcf_set ? 1'b1 :
		((xfer_active_q && scl_rise && bit_cnt_q == '0) ? 1'b0 : transfer_complete_flag_q);

	// Transfer tracking registers
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
		begin
			xfer_active_q <= 1'b0;
			bit_cnt_q <= '0;
			transfer_complete_flag_q <= 1'b1;
		end
		else
		begin
			xfer_active_q <= xfer_active_d;
			bit_cnt_q <= bit_cnt_d;
			transfer_complete_flag_q <= transfer_complete_flag_d;
		end
	end

	// ----------------------------------------------------------------
	// Stop-mode holdoff
	// ----------------------------------------------------------------

	// Acknowledge at once unless holding, the module is enabled and a byte is still on the wire
	assign hold_ok = !stop_hold_enable_q || !module_enable_q || !byte_in_flight || byte_done;
	assign stop_ack_d = stop_req_in && (stop_ack_q || hold_ok);

	// Acknowledge follows the request down; state is all static so a gated clock is harmless
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
			stop_ack_q <= 1'b0;
		else
			stop_ack_q <= stop_ack_d;
	end

	assign stop_ack_out = stop_ack_q;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------

	// Request decode; writes land on the edge after the one that presents ack
	assign req = wb_cyc_in && wb_stb_in;
	assign wr_take = req && wb_we_in && ack_q && wb_sel_in[0];
	assign rd_take = req && !wb_we_in && !ack_q;
	assign wr_filter = wr_take && hit(wb_adr_in, OFS_FILTER_CTL);
	assign wr_module_ctl = wr_take && hit(wb_adr_in, OFS_MODULE_CTL);
	assign wr_module_sts = wr_take && hit(wb_adr_in, OFS_MODULE_STS);
	assign wr_evt_sts = wr_take && hit(wb_adr_in, OFS_EVT_STS);
	assign wr_evt_mask = wr_take && hit(wb_adr_in, OFS_EVT_MASK);

	// Read selection; unmapped addresses read zero
	assign rd_mux =
		hit(wb_adr_in, OFS_FILTER_CTL) ? {24'h00_0000, stop_hold_enable_q, bus_stop_detected_flag_q,
			bus_stop_irq_enable_q, glitch_filter_factor_q} :
		hit(wb_adr_in, OFS_MODULE_CTL) ? {30'h0000_0000, module_irq_enable_q, module_enable_q} :
		hit(wb_adr_in, OFS_MODULE_STS) ? {28'h000_0000, stop_ack_q, xfer_active_q, module_irq_flag_q,
			transfer_complete_flag_q} :
		hit(wb_adr_in, OFS_EVT_STS) ? {29'h0000_0000, evt_q} :
		hit(wb_adr_in, OFS_EVT_MASK) ? {29'h0000_0000, evt_mask_q} : 32'h0000_0000;

	// Ack and read data, one cycle after the request appears
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
		begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end
		else
		begin
			ack_q <= req && !ack_q;
			dat_q <= rd_take ? rd_mux : '0;
		end
	end

	assign wb_ack_out = ack_q;
	assign wb_dat_out = dat_q;

	// Software-written control fields
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
		begin
			stop_hold_enable_q <= RST_STOP_HOLD_EN;
			bus_stop_irq_enable_q <= RST_STOP_IRQ_EN;
			glitch_filter_factor_q <= RST_FACTOR;
			module_enable_q <= RST_MODULE_EN;
			module_irq_enable_q <= RST_MODULE_IRQ_EN;
			evt_mask_q <= RST_EVT_MASK;
		end
		else
		begin
			if (wr_filter)
			begin
				stop_hold_enable_q <= wb_dat_in[POS_STOP_HOLD_EN];
				bus_stop_irq_enable_q <= wb_dat_in[POS_STOP_IRQ_EN];
				glitch_filter_factor_q <= wb_dat_in[POS_FACTOR_LSB +: FACTOR_W];
			end
			if (wr_module_ctl)
			begin
				module_enable_q <= wb_dat_in[POS_MODULE_EN];
				module_irq_enable_q <= wb_dat_in[POS_MODULE_IRQ_EN];
			end
			if (wr_evt_mask)
				evt_mask_q <= wb_dat_in[EVT_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Flags and interrupt
	// ----------------------------------------------------------------

	// Stop flag: hardware set wins over a write-one clear
	assign bus_stop_detected_flag_d = stop_det ||
		(bus_stop_detected_flag_q && !(wr_filter && wb_dat_in[POS_STOP_FLAG]));

	// Module irq flag re-sets while an enabled stop flag remains
	assign module_irq_flag_d = tcf_set || (bus_stop_detected_flag_q && bus_stop_irq_enable_q) ||
		(module_irq_flag_q && !(wr_module_sts && wb_dat_in[POS_MODULE_IRQ_FLAG]));

	// Sticky event bits with write-one clear
	assign evt_set = {stop_ack_d && !stop_ack_q, stop_det, tcf_set};
	assign evt_d = evt_set | (evt_q & ~(wr_evt_sts ? wb_dat_in[EVT_W-1:0] : '0));

	// Held flag survives a stopped clock, so the request appears on wake
	assign irq_d = (module_irq_flag_d && module_irq_enable_q) || (|(evt_d & evt_mask_q));

	// Flag and interrupt registers
	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
		begin
			bus_stop_detected_flag_q <= 1'b0;
			module_irq_flag_q <= 1'b0;
			evt_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			bus_stop_detected_flag_q <= bus_stop_detected_flag_d;
			module_irq_flag_q <= module_irq_flag_d;
			evt_q <= evt_d;
			irq_q <= irq_d;
		end
	end

	assign irq_out = irq_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_hold_while_busy: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(stop_req_in && !stop_ack_q && stop_hold_enable_q && module_enable_q && byte_in_flight && !byte_done)
		|=> !stop_ack_q)
		else $error("stop acknowledged with a byte in flight");
	chk_ack_after_byte: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(stop_req_in && byte_done) ##1 stop_req_in |-> stop_ack_q)
		else $error("stop not acknowledged after the byte ended");
	chk_ack_when_idle: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(stop_req_in && (!xfer_active_q || !module_enable_q)) |=> stop_ack_q)
		else $error("idle module did not acknowledge stop at once");
	chk_tcf_irq_raise: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(tcf_set && module_irq_enable_q) |=> (module_irq_flag_q ##1 irq_out))
		else $error("transfer complete did not raise the interrupt");
	chk_stop_flag_set: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(filt[LINE_SCL] && prev_q[LINE_SCL] && filt[LINE_SDA] && !prev_q[LINE_SDA])
		|=> bus_stop_detected_flag_q)
		else $error("stop condition did not set the flag");
	chk_stop_flag_keep: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(bus_stop_detected_flag_q && !(wr_filter && wb_dat_in[POS_STOP_FLAG])) |=> bus_stop_detected_flag_q)
		else $error("stop flag cleared without a write of one");
	chk_stop_irq_gate: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$rose(module_irq_flag_q) |-> $past(tcf_set || (bus_stop_detected_flag_q && bus_stop_irq_enable_q)))
		else $error("module irq flag set without an enabled cause");
	chk_irq_flag_reset: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(bus_stop_detected_flag_q && bus_stop_irq_enable_q) |=> module_irq_flag_q)
		else $error("module irq flag not re-set by a pending stop flag");
	chk_ack_follows_req: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!stop_req_in |=> !stop_ack_out)
		else $error("stop acknowledge stayed without a request");

endmodule

// ### test/igfsh_bench.sv
`timescale 1ns/1ns
module igfsh_bench;
	import igfsh_pkg::*;
	logic ref_clk, rstn, cyc, stb, we, ack, scl, sda, sreq, sack, irq, gate;
	logic [ADR_W-1:0] adr;
	logic [SEL_W-1:0] sel;
	logic [DAT_W-1:0] wdat, rdat, q;
	logic [8:0] w;
	int miscompares, check_count, seed, f;

	// ----------------------------------------
	// Design, bus model and clock
	// ----------------------------------------
	igfsh_top dut
	(
		.ref_clk_in(ref_clk), .rstn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.scl_in(scl), .sda_in(sda), .stop_req_in(sreq), .stop_ack_out(sack), .irq_out(irq)
	);
	igfsh_bus_model bm
	(
		.clk_in(ref_clk), .scl_out(scl), .sda_out(sda)
	);
	// Clock stands still while gate is high
	initial
	begin
		ref_clk = 1'b0;
		gate = 1'b0;
		forever #5 if (!gate) ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Checks, bus cycles and closing
	// ----------------------------------------
	task automatic chk_reg(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t register %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t pin %b expected %b", $time, got, exp);
		end
	endtask
	// Classic single cycle, held until ack is sampled
	task automatic wb(input logic wr, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
		int n;
		@(posedge ref_clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, wr, a, d, 4'hf};
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rdat;
		{cyc, stb, we} <= 3'h0;
		if (n >= 50)
		begin
			miscompares++;
			$display("[ERR] %0t bus timeout", $time);
		end
	endtask
	task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
		wb(1'b0, a, 32'h0000_0000);
		chk_reg(q, exp);
	endtask
	// Wait a bounded number of edges for the stop acknowledge level
	task automatic wait_ack(input logic exp, input int n);
		for (int i = 0; i < n && sack !== exp; i++)
			@(posedge ref_clk);
		chk_pin(sack, exp);
	endtask
	task automatic set_req(input logic v);
		@(posedge ref_clk);
		sreq <= v;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog against a hang
	initial
	begin
		#900000;
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{rstn, cyc, stb, we, sreq, adr, sel, wdat} = '0;
		miscompares = 0;
		check_count = 0;
		seed = 32'h0000_25e8;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		// Reset values and an unmapped place
		rd(OFS_FILTER_CTL, 32'h0000_0000);
		rd(OFS_MODULE_STS, 32'h0000_0001);
		rd(OFS_EVT_MASK, 32'h0000_0000);
		wb(1'b1, 8'h14, 32'h0000_00ff);
		rd(8'h14, 32'h0000_0000);
		$display("test reset done");
		// Bus stop flag and its one-to-clear
		bm.start();
		bm.stop();
		rd(OFS_FILTER_CTL, 32'h0000_0040);
		// The stop's own clock rise opens a new byte and clears transfer complete
		rd(OFS_MODULE_STS, 32'h0000_0000);
		wb(1'b1, OFS_FILTER_CTL, 32'h0000_0000);
		rd(OFS_FILTER_CTL, 32'h0000_0040);
		wb(1'b1, OFS_FILTER_CTL, 32'h0000_0040);
		rd(OFS_FILTER_CTL, 32'h0000_0000);
		// Event interrupt raised, masked and cleared
		chk_pin(irq, 1'b0);
		wb(1'b1, OFS_EVT_MASK, 32'h0000_0002);
		repeat (3) @(posedge ref_clk);
		chk_pin(irq, 1'b1);
		wb(1'b1, OFS_EVT_STS, 32'h0000_0002);
		wb(1'b1, OFS_EVT_MASK, 32'h0000_0000);
		repeat (3) @(posedge ref_clk);
		chk_pin(irq, 1'b0);
		$display("test stop flag done");
		// Stop interrupt and clearing order
		wb(1'b1, OFS_MODULE_CTL, 32'h0000_0002);
		wb(1'b1, OFS_FILTER_CTL, 32'h0000_0020);
		bm.start();
		bm.stop();
		chk_pin(irq, 1'b1);
		wb(1'b1, OFS_MODULE_STS, 32'h0000_0002);
		rd(OFS_MODULE_STS, 32'h0000_0002);
		wb(1'b1, OFS_FILTER_CTL, 32'h0000_0060);
		wb(1'b1, OFS_MODULE_STS, 32'h0000_0002);
		rd(OFS_MODULE_STS, 32'h0000_0000);
		repeat (3) @(posedge ref_clk);
		chk_pin(irq, 1'b0);
		$display("test stop irq done");
		// Held stop request across a byte in flight
		wb(1'b1, OFS_MODULE_CTL, 32'h0000_0003);
		wb(1'b1, OFS_FILTER_CTL, 32'h0000_0080);
		w = {8'($random(seed)), 1'b0};
		bm.start();
		bm.bits(w, 8, 6);
		sreq <= 1'b1;
		bm.bits(w, 5, 1);
		chk_pin(sack, 1'b0);
		bm.bits(w, 0, 0);
		wait_ack(1'b1, 40);
		rd(OFS_MODULE_STS, 32'h0000_000f);
		// System gates our clock after the acknowledge
		gate = 1'b1;
		#300;
		gate = 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_pin(irq, 1'b1);
		set_req(1'b0);
		wait_ack(1'b0, 3);
		bm.stop();
		wb(1'b1, OFS_EVT_STS, 32'h0000_0007);
		wb(1'b1, OFS_FILTER_CTL, 32'h0000_00c0);
		wb(1'b1, OFS_MODULE_STS, 32'h0000_0002);
		// Idle module acknowledges at once
		set_req(1'b1);
		wait_ack(1'b1, 2);
		set_req(1'b0);
		wait_ack(1'b0, 2);
		rd(OFS_EVT_STS, 32'h0000_0004);
		$display("test holdoff done");
		// Disabled module, then hold off, both mid-byte
		wb(1'b1, OFS_MODULE_CTL, 32'h0000_0002);
		bm.start();
		bm.bits(w, 8, 5);
		set_req(1'b1);
		wait_ack(1'b1, 2);
		set_req(1'b0);
		wait_ack(1'b0, 2);
		wb(1'b1, OFS_MODULE_CTL, 32'h0000_0003);
		wb(1'b1, OFS_FILTER_CTL, 32'h0000_0000);
		set_req(1'b1);
		wait_ack(1'b1, 2);
		set_req(1'b0);
		wait_ack(1'b0, 2);
		// Cut transfer restarted by sending the address again
		bm.start();
		bm.bits(w, 8, 0);
		// Look at transfer complete before the stop's clock rise clears it
		wb(1'b0, OFS_MODULE_STS, 32'h0000_0000);
		chk_pin(q[POS_TCF], 1'b1);
		bm.stop();
		wb(1'b1, OFS_FILTER_CTL, 32'h0000_0040);
		$display("test no hold done");
		// Glitch widths at and beyond the filter factor
		for (int k = 0; k < 4; k++)
		begin
			f = (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 31 : 1 + ($unsigned($random(seed)) % 31);
			wb(1'b1, OFS_FILTER_CTL, 32'(f));
			if (f > 0)
			begin
				bm.glitch(f);
				repeat (2 * f + 10) @(posedge ref_clk);
				rd(OFS_FILTER_CTL, 32'(f));
			end
			bm.glitch(f + 1);
			repeat (2 * f + 10) @(posedge ref_clk);
			rd(OFS_FILTER_CTL, 32'(f) | 32'h0000_0040);
			wb(1'b1, OFS_FILTER_CTL, 32'h0000_0040);
		end
		$display("test filter done");
		finish_test;
	end
endmodule

// ### test/igfsh_bus_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bus master model, 160 ns link period
// ----------------------------------------
module igfsh_bus_model
(
	input wire logic clk_in,
	output logic scl_out,
	output logic sda_out
);
	// Lines rest at the pull-up level between frames
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Wait a number of clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// Start or repeated start: data falls while clock high
	task automatic start();
		sda_out <= 1'b1;
		tick(4);
		scl_out <= 1'b1;
		tick(4);
		sda_out <= 1'b0;
		tick(8);
		scl_out <= 1'b0;
		tick(4);
	endtask
	// Bits hi down to lo, MSB first, data changes only while clock low
	task automatic bits(input logic [8:0] w, input int hi, input int lo);
		for (int i = hi; i >= lo; i--)
		begin
			sda_out <= w[i];
			tick(4);
			scl_out <= 1'b1;
			tick(8);
			scl_out <= 1'b0;
			tick(4);
		end
	endtask
	// Stop: data rises while clock high, then both lines released
	task automatic stop();
		sda_out <= 1'b0;
		tick(4);
		scl_out <= 1'b1;
		tick(8);
		sda_out <= 1'b1;
		tick(8);
	endtask
	// Low pulse of n clocks on the data line while the bus is idle
	task automatic glitch(input int n);
		sda_out <= 1'b0;
		tick(n);
		sda_out <= 1'b1;
		tick(4);
	endtask
endmodule
